// ---- szt_pkg.sv ----
// Shared constants and types of the scale front-panel controller
package szt_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SEC_NS = 1_000_000_000;
  localparam int TICK_CYC = SEC_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 25;
  localparam int HOLD_S = 1;
  localparam logic [11:0] SEG_S = 12'h001;
  localparam logic [11:0] VER_S = 12'h001;
  localparam logic [11:0] SLEEP_S = 12'h03c;
  localparam logic [11:0] OFF_SHORT_S = 12'h2d0;
  localparam logic [11:0] OFF_LONG_S = 12'he10;
  localparam logic [11:0] IDLE_MAX = 12'hfff;

  // ==========================================================
  // Weighing
  localparam int WGT_W = 24;
  localparam logic [23:0] CAP_RST = 24'h002710;
  localparam logic [23:0] TARE_LEGAL_MAX = 24'h00270f;
  localparam logic [23:0] ZERO_FREE_DIV = 24'h000014;
  localparam logic signed [25:0] OVL_MARGIN = 26'sh0000009;
  localparam logic signed [24:0] STAB_BAND = 25'sh0000001;

  // ==========================================================
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CAP = 8'h08;
  localparam logic [7:0] OFS_ZERO = 8'h0c;
  localparam logic [7:0] OFS_TARE = 8'h10;
  localparam logic [7:0] OFS_DISP = 8'h14;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LEGAL_BIT = 2;
  localparam int CTRL_AOEN_BIT = 3;
  localparam int CTRL_AOLONG_BIT = 4;
  localparam int CTRL_DEC_LSB = 5;
  localparam logic [6:0] CTRL_RST = 7'h08;
  localparam int MODE_NET_BIT = 0;
  localparam int MODE_PEAK_BIT = 1;

  // ==========================================================
  // Keys
  localparam int NKEYS = 3;
  localparam int KEY_PWR = 0;
  localparam int KEY_ZERO = 1;
  localparam int KEY_TARE = 2;

  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_SEG = 5'h02,
    ST_VER = 5'h04,
    ST_ERR = 5'h08,
    ST_WGH = 5'h10
  } szt_state_t;

  typedef struct packed {
    logic valid;
    logic motion;
    logic signed [23:0] value;
  } szt_wgt_t;

  typedef struct packed {
    logic signed [23:0] value;
    logic allOn;
    logic showVer;
    logic showErr;
    logic blank;
    logic dim;
    logic ovlWarn;
    logic annNet;
    logic annGross;
    logic [1:0] decimals;
  } szt_disp_t;
endpackage : szt_pkg

// ---- szt_key_sync.sv ----
// Key synchroniser with press pulse per key
`timescale 1ns/10ps
`default_nettype none
module szt_key_sync (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [szt_pkg::NKEYS-1:0] keyPin,
  output logic [szt_pkg::NKEYS-1:0] keyLevel,
  output logic [szt_pkg::NKEYS-1:0] keyPress
);
  // ==========================================================
  // Two-stage synchroniser and edge per key
  genvar i;
  generate
    for (i = 0; i < szt_pkg::NKEYS; i++) begin : g_key
      logic meta_q;
      logic sync_q;
      logic prev_q;
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          prev_q <= 1'b0;
        end else if (ce) begin
          meta_q <= keyPin[i];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      assign keyLevel[i] = sync_q;
      assign keyPress[i] = ce & sync_q & ~prev_q;
    end
  endgenerate
endmodule : szt_key_sync
`default_nettype wire

// ---- szt_panel_ctrl.sv ----
// Front-panel power, zero and tare controller with APB registers
`timescale 1ns/10ps
`default_nettype none
module szt_panel_ctrl #(
  parameter int TICK_CYC = szt_pkg::TICK_CYC,
  parameter logic [23:0] FW_VERSION = 24'h000100
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [szt_pkg::NKEYS-1:0] keyPin,
  input wire szt_pkg::szt_wgt_t wgtIn,
  input wire logic selfTestOk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [szt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic powerOn,
  output szt_pkg::szt_disp_t disp
);
  // ==========================================================
  // Declarations
  szt_pkg::szt_state_t state_q, state_d;
  logic [szt_pkg::NKEYS-1:0] keyLevel, keyPress;
  logic [szt_pkg::TICK_W-1:0] tick_q, hold_q;
  logic [11:0] idle_q;
  logic holdDone_q, flash_q, stable_q, zeroAnn_q, ack_q;
  logic [6:0] ctrl_q;
  logic [23:0] cap_q;
  logic signed [23:0] zero_q, tare_q, prev_q, peak_q;
  logic [31:0] rdata_q;
  szt_pkg::szt_disp_t disp_q, disp_d;

  szt_key_sync u_keys (
    .clock(clock),
    .sys_rst(sys_rst),
    .ce(ce),
    .keyPin(keyPin),
    .keyLevel(keyLevel),
    .keyPress(keyPress)
  );

  // ==========================================================
  // Weight arithmetic
  wire weighing = (state_q == szt_pkg::ST_WGH);
  wire netSel = ctrl_q[szt_pkg::MODE_NET_BIT];
  wire peakSel = ctrl_q[szt_pkg::MODE_PEAK_BIT];
  wire legal = ctrl_q[szt_pkg::CTRL_LEGAL_BIT];
  // Last valid sample; the value lines are unqualified between strobes
  wire signed [23:0] grossW = prev_q - zero_q;
  wire signed [23:0] netW = grossW - tare_q;
  wire signed [23:0] baseW = netSel ? netW : grossW;
  wire signed [24:0] deltaW = $signed({wgtIn.value[23], wgtIn.value})
                            - $signed({prev_q[23], prev_q});
  wire inBand = (deltaW <= szt_pkg::STAB_BAND)
              && (deltaW >= -szt_pkg::STAB_BAND);
  wire moveAct = wgtIn.valid & ~inBand;
  wire keyAct = |keyPress;
  wire activity = weighing & (keyAct | moveAct);
  wire steady = stable_q & ~wgtIn.motion;

  wire signed [25:0] capS = $signed({2'b00, cap_q});
  wire signed [25:0] fiveS = $signed({2'b00, cap_q / szt_pkg::ZERO_FREE_DIV});
  wire signed [25:0] zeroS = $signed({{2{zero_q[23]}}, zero_q});
  wire signed [25:0] excessS = zeroS - fiveS;
  wire signed [25:0] usableS = (excessS > 0) ? capS - excessS : capS;
  wire signed [25:0] grossS = $signed({{2{grossW[23]}}, grossW});
  // overload on gross, i.e. tare plus net
  wire ovl = grossS > usableS + szt_pkg::OVL_MARGIN;

  // ==========================================================
  // Key decisions
  wire zeroKey = weighing & keyPress[szt_pkg::KEY_ZERO];
  wire tareKey = weighing & keyPress[szt_pkg::KEY_TARE];
  wire zeroAcc = zeroKey & steady;
  wire tareFits = ~legal | (grossW <= $signed(szt_pkg::TARE_LEGAL_MAX));
  wire tareAcc = tareKey & ~netSel & steady & (grossW > 0) & tareFits;
  wire tareClr = tareKey & netSel;

  // ==========================================================
  // Timers
  wire secTick = (tick_q == szt_pkg::TICK_W'(TICK_CYC - 1));
  wire stateChg = (state_d != state_q);
  wire holdFire = keyLevel[szt_pkg::KEY_PWR] & ~holdDone_q
    & (hold_q == szt_pkg::TICK_W'(TICK_CYC * szt_pkg::HOLD_S - 1));
  wire [11:0] offLimit = ctrl_q[szt_pkg::CTRL_AOLONG_BIT]
    ? szt_pkg::OFF_LONG_S : szt_pkg::OFF_SHORT_S;
  wire autoOff = ctrl_q[szt_pkg::CTRL_AOEN_BIT] & (idle_q >= offLimit);
  wire sleepy = weighing & (idle_q >= szt_pkg::SLEEP_S);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tick_q <= '0;
      idle_q <= '0;
      flash_q <= 1'b0;
    end else if (ce) begin
      if (stateChg || activity || secTick) begin
        tick_q <= '0;
      end else begin
        tick_q <= tick_q + 1'b1;
      end
      if (stateChg || activity) begin
        idle_q <= '0;
      end else if (secTick && idle_q != szt_pkg::IDLE_MAX) begin
        idle_q <= idle_q + 1'b1;
      end
      if (secTick) begin
        flash_q <= ~flash_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hold_q <= '0;
      holdDone_q <= 1'b0;
    end else if (ce) begin
      if (!keyLevel[szt_pkg::KEY_PWR]) begin
        hold_q <= '0;
        holdDone_q <= 1'b0;
      end else if (holdFire) begin
        holdDone_q <= 1'b1;
      end else if (!holdDone_q) begin
        hold_q <= hold_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // Power state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      szt_pkg::ST_OFF: if (holdFire) state_d = szt_pkg::ST_SEG;
      szt_pkg::ST_SEG: begin
        if (holdFire) state_d = szt_pkg::ST_OFF;
        else if (secTick && idle_q + 1'b1 == szt_pkg::SEG_S)
          state_d = szt_pkg::ST_VER;
      end
      szt_pkg::ST_VER: begin
        if (holdFire) state_d = szt_pkg::ST_OFF;
        else if (secTick && idle_q + 1'b1 == szt_pkg::VER_S)
          state_d = selfTestOk ? szt_pkg::ST_WGH : szt_pkg::ST_ERR;
      end
      szt_pkg::ST_ERR: if (holdFire) state_d = szt_pkg::ST_OFF;
      szt_pkg::ST_WGH: if (holdFire || autoOff) state_d = szt_pkg::ST_OFF;
      default: state_d = szt_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= szt_pkg::ST_OFF;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // APB slave, one wait state
  wire apbAcc = psel & penable;
  wire selCtrl = (paddr == szt_pkg::OFS_CTRL);
  wire selStat = (paddr == szt_pkg::OFS_STATUS);
  wire selCap = (paddr == szt_pkg::OFS_CAP);
  wire selZero = (paddr == szt_pkg::OFS_ZERO);
  wire selTare = (paddr == szt_pkg::OFS_TARE);
  wire selDisp = (paddr == szt_pkg::OFS_DISP);
  wire hit = selCtrl | selStat | selCap | selZero | selTare | selDisp;
  wire wrEn = apbAcc & ack_q & pwrite & hit;
  wire [31:0] statW = {21'h000000, ovl, wgtIn.motion, stable_q, sleepy,
                       powerOn, state_q, holdDone_q};
  wire [31:0] rdMux =
      selCtrl ? {25'h0000000, ctrl_q} :
      selStat ? statW :
      selCap ? {8'h00, cap_q} :
      selZero ? {{8{zero_q[23]}}, zero_q} :
      selTare ? {{8{tare_q[23]}}, tare_q} :
      selDisp ? {{8{disp_q.value[23]}}, disp_q.value} : 32'h00000000;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else if (ce) begin
      ack_q <= apbAcc & ~ack_q;
      if (apbAcc && !ack_q) begin
        rdata_q <= rdMux;
      end
    end
  end

  assign pready = ack_q;
  assign pslverr = ack_q & ~hit;
  assign prdata = rdata_q;

  // ==========================================================
  // Zero, tare, mode and configuration
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_q <= szt_pkg::CTRL_RST;
      cap_q <= szt_pkg::CAP_RST;
      zero_q <= '0;
      tare_q <= '0;
      zeroAnn_q <= 1'b0;
    end else if (ce) begin
      if (wrEn && selCap) cap_q <= pwdata[23:0];
      if (zeroAcc) zero_q <= prev_q;
      else if (wrEn && selZero) zero_q <= pwdata[23:0];
      if (tareAcc) tare_q <= grossW;
      else if (tareClr) tare_q <= '0;
      else if (wrEn && selTare) tare_q <= pwdata[23:0];
      if (wrEn && selCtrl) ctrl_q <= pwdata[6:0];
      if (tareAcc) ctrl_q[szt_pkg::MODE_NET_BIT] <= 1'b1;
      else if (tareClr) ctrl_q[szt_pkg::MODE_NET_BIT] <= 1'b0;
      if (zeroAcc) zeroAnn_q <= 1'b1;
      else if (tareAcc || tareClr) zeroAnn_q <= 1'b0;
    end
  end

  // Stability and peak tracking
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prev_q <= '0;
      stable_q <= 1'b0;
      peak_q <= '0;
    end else if (ce) begin
      if (wgtIn.valid) begin
        prev_q <= wgtIn.value;
        stable_q <= inBand & ~wgtIn.motion;
      end
      if (zeroAcc || tareAcc || tareClr) peak_q <= '0;
      else if (weighing && baseW > peak_q) peak_q <= baseW;
    end
  end

  // ==========================================================
  // Display
  always_comb begin
    disp_d = '0;
    disp_d.decimals = ctrl_q[szt_pkg::CTRL_DEC_LSB +: 2];
    case (state_q)
      szt_pkg::ST_OFF: disp_d.blank = 1'b1;
      szt_pkg::ST_SEG: begin
        disp_d.allOn = 1'b1;
        disp_d.annNet = 1'b1;
        disp_d.annGross = 1'b1;
      end
      szt_pkg::ST_VER: begin
        disp_d.showVer = 1'b1;
        disp_d.value = FW_VERSION;
      end
      szt_pkg::ST_ERR: disp_d.showErr = 1'b1;
      szt_pkg::ST_WGH: begin
        disp_d.value = peakSel ? peak_q : baseW;
        disp_d.annNet = netSel;
        disp_d.annGross = ~netSel | zeroAnn_q;
        disp_d.dim = sleepy;
        disp_d.ovlWarn = ovl;
        disp_d.blank = ovl & flash_q;
      end
      default: disp_d.blank = 1'b1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      disp_q <= '0;
    end else if (ce) begin
      disp_q <= disp_d;
    end
  end

  assign disp = disp_q;
  assign powerOn = (state_q != szt_pkg::ST_OFF);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_autooff;
    ce && weighing && autoOff && !holdFire |=> state_q == szt_pkg::ST_OFF;
  endproperty
  a_autooff: assert property (p_autooff) else $error("no auto off");

  property p_dim;
    ce && weighing && idle_q >= 12'h03c |=> disp.dim;
  endproperty
  a_dim: assert property (p_dim) else $error("display not dimmed");

  property p_ovl;
    ce && weighing && grossS > usableS + 26'sh0000009 |=> disp.ovlWarn;
  endproperty
  a_ovl: assert property (p_ovl) else $error("overload not shown");

  property p_pwr_on;
    ce && state_q == szt_pkg::ST_OFF && holdFire
      |=> state_q == szt_pkg::ST_SEG ##1 disp.allOn;
  endproperty
  a_pwr_on: assert property (p_pwr_on) else $error("power on failed");

  property p_err;
    ce && state_q == szt_pkg::ST_VER && state_d != szt_pkg::ST_OFF
      && secTick && !selfTestOk |=> state_q == szt_pkg::ST_ERR;
  endproperty
  a_err: assert property (p_err) else $error("check failure missed");

  property p_zero_motion;
    ce && zeroKey && wgtIn.motion && !(wrEn && selZero) |=> $stable(zero_q);
  endproperty
  a_zero_motion: assert property (p_zero_motion)
    else $error("zero taken in motion");

  property p_tare_pos;
    ce && tareKey && !netSel && grossW <= 0 && !(wrEn && selTare)
      |=> $stable(tare_q) && !netSel;
  endproperty
  a_tare_pos: assert property (p_tare_pos)
    else $error("nonpositive tare taken");

  property p_tare_legal;
    ce && tareKey && legal && grossW > 24'sh00270f |=> !netSel;
  endproperty
  a_tare_legal: assert property (p_tare_legal)
    else $error("oversize legal tare");

  property p_tare_zero;
    ce && (tareAcc || tareClr) && !(wrEn && selZero) |=> $stable(zero_q);
  endproperty
  a_tare_zero: assert property (p_tare_zero)
    else $error("tare moved zero");

  property p_tare_clr;
    ce && tareClr |=> tare_q == 0 && !netSel;
  endproperty
  a_tare_clr: assert property (p_tare_clr)
    else $error("tare not cleared");

  property p_act;
    ce && activity |=> idle_q == 0;
  endproperty
  a_act: assert property (p_act) else $error("idle not restarted");

  c_tare: cover property (ce && tareAcc);
  c_zero: cover property (ce && zeroAcc);
  c_sleep: cover property (ce && sleepy);
  c_error: cover property (state_q == szt_pkg::ST_ERR);
endmodule : szt_panel_ctrl
`default_nettype wire

// ---- szt_front_model.sv ----
// Model of the operator keys and the weight measurement front end
`timescale 1ns/10ps
`default_nettype none
module szt_front_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [szt_pkg::NKEYS-1:0] keyHold,
  input wire logic [23:0] loadValue,
  input wire logic loadMotion,
  output logic [szt_pkg::NKEYS-1:0] keyPin,
  output var szt_pkg::szt_wgt_t wgtIn
);
  logic [1:0] phase_q;

  // ==========================================================
  // Keys
  // operator hold time
  assign keyPin = keyHold;

  // ==========================================================
  // Weight samples, value line scrambled between strobes
  // motion flag
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phase_q <= 2'h0;
      wgtIn <= '0;
    end else begin
      phase_q <= phase_q + 2'h1;
      wgtIn.valid <= (phase_q == 2'h3);
      wgtIn.motion <= loadMotion;
      wgtIn.value <= (phase_q == 2'h3) ? loadValue : ~loadValue;
    end
  end
endmodule : szt_front_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench of the front-panel controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int TICK = 20;
  // Arbitrary version code
  localparam logic [23:0] FW = 24'h000a5c;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic selfTestOk = 1'b1;
  logic [2:0] keyHold = 3'h0;
  logic [23:0] loadValue = 24'h000000;
  logic loadMotion = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [2:0] keyPin;
  szt_pkg::szt_wgt_t wgtIn;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic powerOn;
  szt_pkg::szt_disp_t disp;
  logic [31:0] dispVal;
  logic [31:0] rd;
  logic err;
  int n1;
  int n2;
  int num_errors = 0;
  int comparisons = 0;

  assign dispVal = {{8{disp.value[23]}}, disp.value};
  always #25 clock = ~clock;

  szt_front_model u_szt_front_model (.clock(clock), .sys_rst(sys_rst),
    .keyHold(keyHold), .loadValue(loadValue), .loadMotion(loadMotion),
    .keyPin(keyPin), .wgtIn(wgtIn));
  szt_panel_ctrl #(.TICK_CYC(TICK), .FW_VERSION(FW)) u_szt_panel_ctrl (
    .clock(clock), .sys_rst(sys_rst), .ce(ce), .keyPin(keyPin),
    .wgtIn(wgtIn), .selfTestOk(selfTestOk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .powerOn(powerOn), .disp(disp));

  // ==========================================================
  // Helpers
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk

  task key(input int k, input int n, input int post);
    @(posedge clock);
    keyHold[k] <= 1'b1;
    repeat (n) @(posedge clock);
    keyHold[k] <= 1'b0;
    repeat (post) @(posedge clock);
  endtask : key

  task load(input int v, input logic m);
    @(posedge clock);
    loadValue <= v[23:0];
    loadMotion <= m;
    repeat (14) @(posedge clock);
  endtask : load

  task waitsig(input int sel, input logic lvl, input int lim, output int n);
    logic s;
    n = 0;
    do begin
      @(negedge clock);
      n++;
      case (sel)
        0: s = disp.allOn;
        1: s = disp.showVer;
        2: s = disp.showErr;
        3: s = powerOn;
        5: s = disp.blank;
        default: s = disp.dim;
      endcase
    end while (s !== lvl && n < lim);
    chk("wait level", {31'h0, lvl}, {31'h0, s});
  endtask : waitsig

  // ==========================================================
  // Watchdog
  initial begin
    repeat (60000) @(posedge clock);
    num_errors++;
    $display("BAD watchdog expected end seen hang");
    final_report();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    rdchk(szt_pkg::OFS_CTRL, 32'h8, "ctrl");
    rdchk(szt_pkg::OFS_CAP, 32'h2710, "cap");
    rdchk(szt_pkg::OFS_ZERO, 32'h0, "zero");
    rdchk(szt_pkg::OFS_TARE, 32'h0, "tare");
    apb(1'b1, 8'h18, 32'hffffffff);
    chk("wr err", 32'h1, {31'h0, err});
    apb(1'b0, 8'h18, 32'h0);
    chk("rd err", 32'h1, {31'h0, err});
    chk("rd unmapped", 32'h0, rd);
    $display("test registers done");
    selfTestOk <= 1'b0;
    key(szt_pkg::KEY_PWR, TICK - 4, 4);
    chk("short press", 32'h0, {31'h0, powerOn});
    key(szt_pkg::KEY_PWR, TICK + 3, 0);
    waitsig(0, 1'b1, 100, n1);
    chk("power", 32'h1, {31'h0, powerOn});
    waitsig(1, 1'b1, 60, n1);
    chk("seg time", 32'h1, {31'h0, n1 >= 18 && n1 <= 22});
    chk("version", {8'h0, FW}, dispVal);
    waitsig(2, 1'b1, 60, n1);
    chk("ver time", 32'h1, {31'h0, n1 >= 18 && n1 <= 22});
    key(szt_pkg::KEY_PWR, TICK + 10, 0);
    waitsig(3, 1'b0, 80, n1);
    selfTestOk <= 1'b1;
    key(szt_pkg::KEY_PWR, TICK + 10, 0);
    waitsig(1, 1'b1, 200, n1);
    waitsig(1, 1'b0, 60, n1);
    repeat (2) @(negedge clock);
    chk("err", 32'h0, {31'h0, disp.showErr});
    chk("gross", 32'h1, {31'h0, disp.annGross});
    $display("test power-up done");
    apb(1'b1, szt_pkg::OFS_CTRL, 32'h48);
    load(50, 1'b1);
    key(szt_pkg::KEY_ZERO, 3, 8);
    rdchk(szt_pkg::OFS_ZERO, 32'h0, "zero moving");
    load(50, 1'b0);
    key(szt_pkg::KEY_ZERO, 3, 8);
    rdchk(szt_pkg::OFS_ZERO, 32'd50, "zero");
    @(negedge clock);
    chk("value", 32'h0, dispVal);
    chk("gross", 32'h1, {31'h0, disp.annGross});
    chk("decimals", 32'h2, {30'h0, disp.decimals});
    load(40, 1'b0);
    key(szt_pkg::KEY_TARE, 3, 8);
    rdchk(szt_pkg::OFS_TARE, 32'h0, "tare neg");
    load(80, 1'b1);
    key(szt_pkg::KEY_TARE, 3, 8);
    rdchk(szt_pkg::OFS_TARE, 32'h0, "tare moving");
    load(80, 1'b0);
    key(szt_pkg::KEY_TARE, 3, 8);
    rdchk(szt_pkg::OFS_TARE, 32'd30, "tare");
    @(negedge clock);
    chk("net", 32'h1, {31'h0, disp.annNet});
    chk("value", 32'h0, dispVal);
    rdchk(szt_pkg::OFS_ZERO, 32'd50, "zero kept");
    load(90, 1'b0);
    chk("value", 32'd10, dispVal);
    rdchk(szt_pkg::OFS_DISP, 32'd10, "disp reg");
    key(szt_pkg::KEY_ZERO, 3, 8);
    rdchk(szt_pkg::OFS_ZERO, 32'd90, "zero");
    @(negedge clock);
    chk("value", 32'hffffffe2, dispVal);
    key(szt_pkg::KEY_TARE, 3, 8);
    rdchk(szt_pkg::OFS_TARE, 32'h0, "tare clear");
    @(negedge clock);
    chk("gross", 32'h1, {31'h0, disp.annGross});
    $display("test zero and tare done");
    apb(1'b1, szt_pkg::OFS_CTRL, 32'h4c);
    load(10090, 1'b0);
    key(szt_pkg::KEY_TARE, 3, 8);
    rdchk(szt_pkg::OFS_TARE, 32'h0, "tare legal");
    @(negedge clock);
    chk("net", 32'h0, {31'h0, disp.annNet});
    load(10089, 1'b0);
    key(szt_pkg::KEY_TARE, 3, 8);
    rdchk(szt_pkg::OFS_TARE, 32'd9999, "tare legal");
    key(szt_pkg::KEY_TARE, 3, 8);
    load(1090, 1'b0);
    key(szt_pkg::KEY_TARE, 3, 8);
    rdchk(szt_pkg::OFS_TARE, 32'd1000, "tare");
    load(10099, 1'b0);
    @(negedge clock);
    chk("overload", 32'h0, {31'h0, disp.ovlWarn});
    load(10100, 1'b0);
    @(negedge clock);
    chk("overload", 32'h1, {31'h0, disp.ovlWarn});
    waitsig(5, 1'b1, 50, n1);
    waitsig(5, 1'b0, 50, n1);
    apb(1'b1, szt_pkg::OFS_CTRL, 32'h4f);
    repeat (2) @(negedge clock);
    chk("peak", 32'd9010, dispVal);
    $display("test legal and overload done");
    load(1090, 1'b0);
    waitsig(4, 1'b1, 2000, n1);
    chk("dim time", 32'h1, {31'h0, n1 + 14 >= 1175 && n1 + 14 <= 1230});
    key(szt_pkg::KEY_ZERO, 3, 0);
    waitsig(4, 1'b0, 20, n1);
    waitsig(3, 1'b0, 16000, n2);
    chk("off time", 32'h1, {31'h0, n1 + n2 >= 14346 && n1 + n2 <= 14436});
    rdchk(szt_pkg::OFS_ZERO, 32'd1090, "zero kept");
    rdchk(szt_pkg::OFS_TARE, 32'd1000, "tare kept");
    rdchk(szt_pkg::OFS_STATUS, 32'h102, "status");
    $display("test timers done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
